// File: etw_defines.svh
`ifndef ETW_DEFINES_SVH
`define ETW_DEFINES_SVH

// register map
`define ETW_ADDR_W 8
`define ETW_DATA_W 8
`define ETW_BUS_CONTROL_ADDR 8'h90

// field positions of eeprom_bus_control
`define ETW_POWER_BIT 0
`define ETW_DATA_BIT 1
`define ETW_CLOCK_BIT 2

// reset values of the writable bits
`define ETW_POWER_RESET 1'b1
`define ETW_DATA_RESET 1'b1
`define ETW_CLOCK_RESET 1'b1

// memory geometry
`define ETW_MEM_DEPTH 128
`define ETW_PTR_W 7
`define ETW_BYTE_BITS 4'h8

`endif

// File: etw_pkg.sv
package etw_pkg;

  typedef enum logic [8:0] {
    etw_idle = 9'h001,
    etw_ctrl = 9'h002,
    etw_ctrl_ack = 9'h004,
    etw_ptr = 9'h008,
    etw_ptr_ack = 9'h010,
    etw_wdata = 9'h020,
    etw_wdata_ack = 9'h040,
    etw_rdata = 9'h080,
    etw_rdata_ack = 9'h100
  } etw_state_type;

  typedef logic [7:0] etw_byte_type;

endpackage : etw_pkg

// File: etw_eeprom_two_wire_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "etw_defines.svh"

module etw_eeprom_two_wire_port #(
  parameter logic [6:0] DEVICE_SELECT = 7'h50 // arbitrary value
) (
  // core clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // memory side clock
  input wire logic link_clk,
  // register port
  input wire logic [`ETW_ADDR_W-1:0] reg_addr,
  input wire logic [`ETW_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`ETW_DATA_W-1:0] reg_rdata,
  // observed bus
  output logic mem_power,
  output logic bus_clock,
  output logic bus_clock_oe,
  output logic bus_data,
  output logic bus_data_oe
);
  import etw_pkg::*;

  // core domain register bits
  logic power_bit;
  logic data_bit;
  logic clock_bit;
  logic next_power_bit;
  logic next_data_bit;
  logic next_clock_bit;
  logic [`ETW_DATA_W-1:0] next_reg_rdata;
  logic data_sync_a;
  logic data_sync_b;

  // shared line levels
  logic master_drive_low;
  logic slave_drive_low;
  logic data_line;
  logic clock_line;

  // memory domain state
  logic clk_s1;
  logic clk_s2;
  logic clk_d;
  logic dat_s1;
  logic dat_s2;
  logic dat_d;
  logic pwr_s1;
  logic pwr_s2;
  etw_state_type state;
  etw_state_type next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  etw_byte_type shift;
  etw_byte_type next_shift;
  etw_byte_type tx;
  etw_byte_type next_tx;
  logic [`ETW_PTR_W-1:0] ptr;
  logic [`ETW_PTR_W-1:0] next_ptr;
  logic drive;
  logic next_drive;
  logic rw;
  logic next_rw;
  logic nack;
  logic next_nack;
  logic mem_we;
  etw_byte_type mem [0:`ETW_MEM_DEPTH-1];

  function automatic logic reg_hit(input logic [`ETW_ADDR_W-1:0] a);
    reg_hit = (a == `ETW_BUS_CONTROL_ADDR);
  endfunction : reg_hit

  // line levels from software and memory-side drivers
  assign master_drive_low = power_bit & ~data_bit;
  assign slave_drive_low = power_bit & drive;
  assign data_line = ~(master_drive_low | slave_drive_low);
  assign clock_line = power_bit & clock_bit;

  assign mem_power = power_bit;
  assign bus_clock_oe = power_bit;
  assign bus_clock = clock_line;
  assign bus_data_oe = master_drive_low;
  assign bus_data = data_line;

  // register writes and reads
  always_comb begin
    next_power_bit = power_bit;
    next_data_bit = data_bit;
    next_clock_bit = clock_bit;
    next_reg_rdata = '0;
    if (reg_write && reg_hit(reg_addr)) begin
      next_power_bit = reg_wdata[`ETW_POWER_BIT];
      next_data_bit = reg_wdata[`ETW_DATA_BIT];
      next_clock_bit = reg_wdata[`ETW_CLOCK_BIT];
    end
    if (reg_read && reg_hit(reg_addr)) begin
      next_reg_rdata[`ETW_POWER_BIT] = power_bit;
      next_reg_rdata[`ETW_DATA_BIT] = power_bit & data_sync_b;
      next_reg_rdata[`ETW_CLOCK_BIT] = power_bit & clock_bit;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_bit <= `ETW_POWER_RESET;
      data_bit <= `ETW_DATA_RESET;
      clock_bit <= `ETW_CLOCK_RESET;
      reg_rdata <= '0;
      data_sync_a <= 1'b1;
      data_sync_b <= 1'b1;
    end else begin
      power_bit <= next_power_bit;
      data_bit <= next_data_bit;
      clock_bit <= next_clock_bit;
      reg_rdata <= next_reg_rdata;
      data_sync_a <= data_line;
      data_sync_b <= data_sync_a;
    end
  end

  // memory side: line sampling
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_s1 <= 1'b1;
      clk_s2 <= 1'b1;
      clk_d <= 1'b1;
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
      dat_d <= 1'b1;
      pwr_s1 <= 1'b0;
      pwr_s2 <= 1'b0;
    end else begin
      clk_s1 <= clock_line;
      clk_s2 <= clk_s1;
      clk_d <= clk_s2;
      dat_s1 <= data_line;
      dat_s2 <= dat_s1;
      dat_d <= dat_s2;
      pwr_s1 <= power_bit;
      pwr_s2 <= pwr_s1;
    end
  end

  logic clk_rise;
  logic clk_fall;
  logic start_cond;
  logic stop_cond;
  assign clk_rise = clk_s2 & ~clk_d;
  assign clk_fall = ~clk_s2 & clk_d;
  // data moving while clock high marks start or stop
  assign start_cond = clk_s2 & clk_d & dat_d & ~dat_s2;
  assign stop_cond = clk_s2 & clk_d & ~dat_d & dat_s2;

  // memory side: protocol engine
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_tx = tx;
    next_ptr = ptr;
    next_drive = drive;
    next_rw = rw;
    next_nack = nack;
    mem_we = 1'b0;
    if (!pwr_s2) begin
      next_state = etw_idle;
      next_cnt = 4'h0;
      next_drive = 1'b0;
    end else if (start_cond) begin
      next_state = etw_ctrl;
      next_cnt = 4'h0;
      next_drive = 1'b0;
    end else if (stop_cond) begin
      next_state = etw_idle;
      next_drive = 1'b0;
    end else begin
      case (state)
        etw_ctrl, etw_ptr, etw_wdata: begin
          if (clk_rise) begin
            next_shift = {shift[6:0], dat_s2};
            next_cnt = cnt + 4'h1;
          end else if (clk_fall && cnt == `ETW_BYTE_BITS) begin
            next_cnt = 4'h0;
            next_drive = 1'b1;
            if (state == etw_ctrl) begin
              if (shift[7:1] == DEVICE_SELECT) begin
                next_rw = shift[0];
                next_state = etw_ctrl_ack;
              end else begin
                next_drive = 1'b0;
                next_state = etw_idle;
              end
            end else if (state == etw_ptr) begin
              next_ptr = shift[`ETW_PTR_W-1:0];
              next_state = etw_ptr_ack;
            end else begin
              mem_we = 1'b1;
              next_ptr = ptr + 7'h01;
              next_state = etw_wdata_ack;
            end
          end
        end
        etw_ctrl_ack, etw_ptr_ack, etw_wdata_ack: begin
          if (clk_fall) begin
            next_drive = 1'b0;
            if (state == etw_ctrl_ack && rw) begin
              // read from the held address, no pointer phase
              next_tx = mem[ptr];
              next_ptr = ptr + 7'h01;
              next_drive = ~mem[ptr][7];
              next_state = etw_rdata;
            end else if (state == etw_ctrl_ack) begin
              next_state = etw_ptr;
            end else begin
              next_state = etw_wdata;
            end
          end
        end
        etw_rdata: begin
          if (clk_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (clk_fall) begin
            if (cnt == `ETW_BYTE_BITS) begin
              next_cnt = 4'h0;
              next_drive = 1'b0;
              next_state = etw_rdata_ack;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_drive = ~tx[6];
            end
          end
        end
        etw_rdata_ack: begin
          if (clk_rise) begin
            next_nack = dat_s2;
          end else if (clk_fall) begin
            if (nack) begin
              next_state = etw_idle;
            end else begin
              next_tx = mem[ptr];
              next_ptr = ptr + 7'h01;
              next_drive = ~mem[ptr][7];
              next_state = etw_rdata;
            end
          end
        end
        etw_idle: begin
          next_drive = 1'b0;
        end
        default: begin
          next_state = etw_idle;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= etw_idle;
      cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 7'h00;
      drive <= 1'b0;
      rw <= 1'b0;
      nack <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      tx <= next_tx;
      ptr <= next_ptr;
      drive <= next_drive;
      rw <= next_rw;
      nack <= next_nack;
    end
  end

  // data storage, kept while unpowered
  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[ptr] <= shift;
    end
  end

endmodule : etw_eeprom_two_wire_port
`default_nettype wire

// File: etw_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "etw_defines.svh"
module etw_properties (
  // clocks and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  // register port
  input wire logic [`ETW_ADDR_W-1:0] reg_addr,
  input wire logic [`ETW_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [`ETW_DATA_W-1:0] reg_rdata,
  // bus
  input wire logic mem_power,
  input wire logic bus_clock,
  input wire logic bus_clock_oe,
  input wire logic bus_data,
  input wire logic bus_data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_read_fields: assert property (
    $past(reg_read) && $past(reg_addr) == 8'h90 |-> reg_rdata[0] == $past(mem_power)
    && reg_rdata[2] == $past(bus_clock) && reg_rdata[7:3] == 5'h00)
    else $error("read fields wrong");
  a_data_readback: assert property (
    $past(reg_read) && $past(reg_addr) == 8'h90 |-> reg_rdata[1] == ($past(mem_power)
    && $past(bus_data, 3))) else $error("data readback wrong");
  a_off_reads_zero: assert property (
    $past(reg_read) && !$past(mem_power) |-> reg_rdata == 8'h00) else $error("off read");
  a_unmapped_read: assert property (
    $past(reg_read) && $past(reg_addr) != 8'h90 |-> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_write_lines: assert property (
    reg_write && reg_addr == 8'h90 |=> mem_power == $past(reg_wdata[0])
    && bus_clock == ($past(reg_wdata[2]) && mem_power)) else $error("write lines");
  a_data_enable: assert property (
    reg_write && reg_addr == 8'h90 |=> bus_data_oe == (mem_power && !$past(reg_wdata[1])))
    else $error("data enable");
  a_data_drive: assert property (
    bus_data_oe |-> !bus_data) else $error("data not low");
  a_clock_enable: assert property (
    bus_clock_oe == mem_power) else $error("clock enable");
  a_unmapped_hold: assert property (
    reg_write && reg_addr != 8'h90 |=> $stable(mem_power) && $stable(bus_clock)
    && $stable(bus_data_oe)) else $error("unmapped write");
  c_power_off: cover property (reg_write && reg_addr == 8'h90 && !reg_wdata[0]);
  c_start: cover property (bus_clock && $fell(bus_data));
  c_low_read: cover property ($past(reg_read) && reg_rdata == 8'h05);
endmodule : etw_properties
bind etw_eeprom_two_wire_port etw_properties i_etw_properties (.clk, .reset_n, .link_clk,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .mem_power, .bus_clock,
  .bus_clock_oe, .bus_data, .bus_data_oe);
`default_nettype wire

// File: etw_bus_watch.sv
`timescale 1ns/1ps
`default_nettype none
module etw_bus_watch (
  // memory side clock
  input wire logic link_clk,
  input wire logic reset_n,
  // bus lines
  input wire logic bus_clock,
  input wire logic bus_data,
  // frame counts
  output var int starts,
  output var int stops
);
  logic pc = 1'b1;
  logic pd = 1'b1;
  always @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      starts <= 0;
      stops <= 0;
    end else begin
      // data moves with clock high only to frame a transfer
      if (pc && bus_clock && pd && !bus_data) starts <= starts + 1;
      if (pc && bus_clock && !pd && bus_data) stops <= stops + 1;
    end
    pc <= bus_clock;
    pd <= bus_data;
  end
endmodule : etw_bus_watch
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [6:0] sel = 7'h50; // arbitrary value
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic mem_power, bus_clock, bus_clock_oe, bus_data, bus_data_oe;
  logic [7:0] v;
  int starts, stops;
  int mismatches = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  initial begin
    #2;
    forever #6 link_clk = ~link_clk;
  end
  etw_eeprom_two_wire_port #(.DEVICE_SELECT(sel)) i_etw_eeprom_two_wire_port (.clk(clk),
    .reset_n(reset_n), .link_clk(link_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem_power(mem_power), .bus_clock(bus_clock), .bus_clock_oe(bus_clock_oe),
    .bus_data(bus_data), .bus_data_oe(bus_data_oe));
  etw_bus_watch i_etw_bus_watch (.link_clk(link_clk), .reset_n(reset_n),
    .bus_clock(bus_clock), .bus_data(bus_data), .starts(starts), .stops(stops));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    r = reg_rdata;
  endtask : rd
  task automatic line(input logic c, input logic d);
    wr(8'h90, {5'h00, c, d, 1'b1});
    repeat (30) @(posedge clk);
  endtask : line
  task automatic bit_out(input logic b);
    line(1'b0, b);
    line(1'b1, b);
    line(1'b0, b);
  endtask : bit_out
  task automatic start;
    line(1'b1, 1'b1);
    line(1'b1, 1'b0);
    line(1'b0, 1'b0);
  endtask : start
  task automatic stop;
    line(1'b0, 1'b0);
    line(1'b1, 1'b0);
    line(1'b1, 1'b1);
  endtask : stop
  task automatic sbyte(input logic [7:0] b, input logic e);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    line(1'b0, 1'b1);
    line(1'b1, 1'b1);
    rd(8'h90, r);
    chk("ack", {7'h00, e}, {7'h00, r[1]});
    line(1'b0, 1'b1);
  endtask : sbyte
  task automatic rbyte(input logic a, output logic [7:0] b);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      line(1'b1, 1'b1);
      rd(8'h90, r);
      b[i] = r[1];
      line(1'b0, 1'b1);
    end
    bit_out(a);
  endtask : rbyte
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(8'h90, v);
    chk("reset value", 8'h07, v);
    wr(8'h90, 8'h05);
    repeat (10) @(posedge clk);
    rd(8'h90, v);
    chk("data low", 8'h05, v);
    chk("data pins", 8'h02, {6'h00, bus_data_oe, bus_data});
    wr(8'h90, 8'h06);
    repeat (10) @(posedge clk);
    rd(8'h90, v);
    chk("power off", 8'h00, v);
    chk("off pins", 8'h00, {5'h00, mem_power, bus_clock_oe, bus_clock});
    wr(8'h91, 8'h07);
    rd(8'h91, v);
    chk("unmapped read", 8'h00, v);
    rd(8'h90, v);
    chk("unmapped write", 8'h00, v);
    wr(8'h90, 8'h07);
    repeat (30) @(posedge clk);
    rd(8'h90, v);
    chk("power on", 8'h07, v);
    start();
    sbyte({sel, 1'b0}, 1'b0);
    sbyte(8'h12, 1'b0);
    sbyte(8'h5a, 1'b0);
    sbyte(8'hc3, 1'b0);
    stop();
    start();
    sbyte({sel, 1'b0}, 1'b0);
    sbyte(8'h12, 1'b0);
    start();
    sbyte({sel, 1'b1}, 1'b0);
    rbyte(1'b1, v);
    chk("random read", 8'h5a, v);
    stop();
    start();
    sbyte({sel, 1'b1}, 1'b0);
    rbyte(1'b1, v);
    chk("current read", 8'hc3, v);
    stop();
    start();
    sbyte({7'h51, 1'b0}, 1'b1);
    stop();
    chk("starts", 8'h06, starts[7:0]);
    chk("stops", 8'h04, stops[7:0]);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
